// File: dv/cfg_host.sv
`timescale 1ns/100ps
module cfg_host (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] cfg_rdata_out,
  input  wire logic       cfg_rvalid_out,
  output fuse_prog_pkg::cfg_req_t cfg_req_in
);
  import fuse_prog_pkg::*;
  initial cfg_req_in = '0;
  // one access, launched at a falling edge and held over one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in) cfg_req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys_in) cfg_req_in = '0;
  endtask : wr
  // read answer is taken in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_in) cfg_req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys_in) cfg_req_in = '0;
    d = cfg_rvalid_out ? cfg_rdata_out : 8'hxx;
  endtask : rd
endmodule : cfg_host

// File: dv/efuse_primary_program_control_test.sv
`timescale 1ns/100ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, act, exp); end end
module efuse_primary_program_control_test;
  import fuse_prog_pkg::*;
  logic                     clk_sys_in, nrst_in, fuse_wake_dis_in, cfg_rvalid_out, manual_wake_out;
  logic [7:0]               cfg_rdata_out, page_sel_out, page_locked_out, v;
  logic [6:0]               force_on_out;
  fuse_prog_pkg::cfg_req_t  cfg_req_in;
  fuse_prog_pkg::fuse_cmd_t fuse_cmd_out;
  int                       err_count, comparisons;
  efuse_primary_program_control efuse_primary_program_control_inst (.*);
  cfg_host cfg_host_inst (.*);
  // free-running clock
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic do_reset(input logic dis);
    nrst_in = 1'b0;
    fuse_wake_dis_in = dis;
    repeat (3) @(negedge clk_sys_in);
    nrst_in = 1'b1;
  endtask : do_reset
  // every page code switches, the illegal code four above it is refused
  task automatic t_pages;
    logic [7:0] c [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
    foreach (c[i]) begin
      cfg_host_inst.wr(ADDR_PAGE_SEL, c[i]);
      cfg_host_inst.wr(ADDR_PAGE_SEL, c[i] + 8'h04);
      cfg_host_inst.rd(ADDR_PAGE_SEL, v);
      `CHK(v, c[i])
    end
  endtask : t_pages
  // force registers live on the master page only; output is their and
  task automatic t_force;
    cfg_host_inst.rd(8'h10, v);
    `CHK(v, 8'h00)
    cfg_host_inst.wr(ADDR_PAGE_SEL, 8'h02);
    cfg_host_inst.wr(ADDR_FORCE_OVR, 8'h7f);
    cfg_host_inst.rd(ADDR_FORCE_OVR, v);
    `CHK(v, 8'h00)
    cfg_host_inst.wr(ADDR_PAGE_SEL, PAGE_MASTER);
    cfg_host_inst.wr(ADDR_FORCE_OVR, 8'h55);
    cfg_host_inst.wr(ADDR_FORCE_EN, 8'h33);
    @(negedge clk_sys_in);
    `CHK(force_on_out, 7'h11)
    cfg_host_inst.rd(ADDR_FORCE_EN, v);
    `CHK(v, 8'h33)
    cfg_host_inst.wr(ADDR_FORCE_OVR, 8'h7f);
    cfg_host_inst.wr(ADDR_FORCE_EN, 8'h7f);
    @(negedge clk_sys_in);
    `CHK(force_on_out, 7'h7f)
  endtask : t_force
  // lock and fire each page, master last with lock bit 4 set; manual wake-up stays on
  task automatic t_program;
    logic [7:0] c [8] = '{8'h02, 8'h01, 8'h03, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h00};
    logic [7:0] lw, lk;
    logic [2:0] idx;
    lk = 8'h00;
    foreach (c[i]) begin
      idx = c[i] < 8'h04 ? c[i][2:0] : c[i][2:0] + 3'h2;
      lw = (i == 7) ? 8'h50 : 8'h40;
      lk[idx] = 1'b1;
      cfg_host_inst.wr(ADDR_PAGE_SEL, c[i]);
      cfg_host_inst.wr(ADDR_LOCK_WAKE, lw);
      cfg_host_inst.wr(ADDR_FUSE_CMD, 8'h00);
      cfg_host_inst.wr(ADDR_FUSE_CMD, CMD_BYTE_ALT);
      `CHK(fuse_cmd_out, {1'b1, idx, lw})
      cfg_host_inst.wr(ADDR_FUSE_CMD, 8'h00);
      `CHK(page_locked_out, lk)
      `CHK(manual_wake_out, 1'b1)
    end
  endtask : t_program
  // the plain field code fires too; writing it again while it stands is refused
  task automatic t_code;
    cfg_host_inst.wr(ADDR_PAGE_SEL, PAGE_OUTPUT);
    cfg_host_inst.wr(ADDR_FUSE_CMD, 8'h00);
    cfg_host_inst.wr(ADDR_FUSE_CMD, {CMD_FUSE_WRITE, 3'h0});
    `CHK(fuse_cmd_out, {1'b1, IDX_OUTPUT, 8'h40})
    cfg_host_inst.wr(ADDR_FUSE_CMD, {CMD_FUSE_WRITE, 3'h7});
    `CHK(fuse_cmd_out.start, 1'b0)
  endtask : t_code
  // wake mode after reset follows the stored fuse bit; the page returns to master
  task automatic t_wake(input logic dis);
    cfg_host_inst.wr(ADDR_PAGE_SEL, PAGE_SYNTH_D);
    do_reset(dis);
    repeat (3) @(negedge clk_sys_in);
    `CHK(manual_wake_out, !dis)
    `CHK(page_sel_out, PAGE_MASTER)
  endtask : t_wake
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // watchdog
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    do_reset(1'b0);
    @(negedge clk_sys_in);
    `CHK(manual_wake_out, 1'b1)
    t_pages();
    t_force();
    t_program();
    t_code();
    t_wake(1'b1);
    t_wake(1'b0);
    report_and_stop();
  end
endmodule : efuse_primary_program_control_test

// File: dv/fuse_prog_checker.sv
`timescale 1ns/100ps
module fuse_prog_checker (
  input wire logic                     clk_sys_in,
  input wire logic                     nrst_in,
  input wire fuse_prog_pkg::cfg_req_t  cfg_req_in,
  input wire logic                     fuse_wake_dis_in,
  input wire logic [7:0]               cfg_rdata_out,
  input wire logic                     cfg_rvalid_out,
  input wire logic [7:0]               page_sel_out,
  input wire fuse_prog_pkg::fuse_cmd_t fuse_cmd_out,
  input wire logic [7:0]               page_locked_out,
  input wire logic [6:0]               force_on_out,
  input wire logic                     manual_wake_out
);
  import fuse_prog_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // request fields and legal page code
  wire logic       wr = cfg_req_in.wr;
  wire logic [7:0] a  = cfg_req_in.addr;
  wire logic [7:0] d  = cfg_req_in.wdata;
  wire logic       ok = d <= PAGE_OUTPUT || (d >= PAGE_SYNTH_A && d <= PAGE_SYNTH_D);
  // manual wake held through reset, then taken from the fuse bit seen at the first edge after release
  sequence s_wake;
    manual_wake_out ##1 manual_wake_out == !$past(fuse_wake_dis_in);
  endsequence
  AST_RVALID: assert property (cfg_req_in.rd |=> cfg_rvalid_out) else $error("read not answered");
  AST_PAGE_RD: assert property (cfg_req_in.rd && a == ADDR_PAGE_SEL |=>
    cfg_rdata_out == $past(page_sel_out)) else $error("page readback wrong");
  AST_PAGE_WR: assert property (wr && a == ADDR_PAGE_SEL && ok |=> page_sel_out == $past(d))
    else $error("page not switched");
  AST_PAGE_BAD: assert property (wr && a == ADDR_PAGE_SEL && !ok |=> $stable(page_sel_out))
    else $error("bad page code taken");
  AST_FORCE: assert property (!$stable(force_on_out) |->
    $past(wr && (a == ADDR_FORCE_OVR || a == ADDR_FORCE_EN) && page_sel_out == PAGE_MASTER, 2))
    else $error("force changed without master write");
  AST_LOCK: assert property (!$stable(page_locked_out) |-> $past(wr && a == ADDR_LOCK_WAKE, 2))
    else $error("lock changed without write");
  AST_START: assert property (fuse_cmd_out.start |->
    $past(wr && a == ADDR_FUSE_CMD) ##1 !fuse_cmd_out.start) else $error("stray fuse start");
  AST_START_PG: assert property (fuse_cmd_out.start |-> fuse_cmd_out.page ==
    $past(page_sel_out < 8'h04 ? page_sel_out[2:0] : page_sel_out[2:0] + 3'h2)) else $error("wrong page");
  AST_MANUAL: assert property ($past(nrst_in, 3) && $past(nrst_in, 2) && $past(nrst_in) |->
    $stable(manual_wake_out)) else $error("wake mode changed in run");
  AST_WAKE: assert property ($rose(nrst_in) |-> s_wake) else $error("wake mode after reset wrong");
endmodule : fuse_prog_checker
bind efuse_primary_program_control fuse_prog_checker fuse_prog_checker_inst (.*);

// File: logic/efuse_primary_program_control.sv
`timescale 1ns/100ps
// Summary of operation
// - master 0xE0 bits 0..6 enable forced power override per subsystem
// - master 0xE1 bits 0..6 request enable per subsystem, same order
// - every page has lock field 0x2f[7:6]; value 1 marks page locked
// - pages: 0 master, 1 clock monitor, 2 input, 3 output, A-D synths
// - every page: 0x0f[7:3] written 0x0C starts fuse write of that page
// - manual wake-up of slaves is used while fuses are programmed
// - master 0x2f bit 4 disables manual wake-up once stored in fuses
// - page switches on write to 0xFF; codes 0x00-0x03 and 0x0A-0x0D
// - after master written, reset makes device wake from primary fuses
module efuse_primary_program_control (
  input  wire logic                   clk_sys_in,
  input  wire logic                   nrst_in,
  input  wire fuse_prog_pkg::cfg_req_t cfg_req_in,
  input  wire logic                   fuse_wake_dis_in,
  output logic [7:0]                  cfg_rdata_out,
  output logic                        cfg_rvalid_out,
  output logic [7:0]                  page_sel_out,
  output fuse_prog_pkg::fuse_cmd_t    fuse_cmd_out,
  output logic [7:0]                  page_locked_out,
  output logic [6:0]                  force_on_out,
  output logic                        manual_wake_out
);
  import fuse_prog_pkg::*;

  // page code valid check
  function automatic logic page_valid(input logic [7:0] code);
    page_valid = (code <= PAGE_OUTPUT) || ((code >= PAGE_SYNTH_A) && (code <= PAGE_SYNTH_D));
  endfunction : page_valid

  // page code to index
  function automatic logic [2:0] page_index(input logic [7:0] code);
    logic [7:0] off;
    off = code - PAGE_SYNTH_A;
    if (code <= PAGE_OUTPUT) begin
      page_index = code[2:0];
    end else begin
      page_index = IDX_SYNTH_A + off[2:0];
    end
  endfunction : page_index

  // command byte carries the fuse write code
  function automatic logic is_fuse_cmd(input logic [7:0] b);
    is_fuse_cmd = (b[CMD_MSB:CMD_LSB] == CMD_FUSE_WRITE) || (b == CMD_BYTE_ALT);
  endfunction : is_fuse_cmd

  logic [7:0] page_reg,       page_next;
  logic [7:0] cmd_reg  [NUM_PAGES], cmd_next  [NUM_PAGES];
  logic [7:0] lock_reg [NUM_PAGES], lock_next [NUM_PAGES];
  logic [6:0] ovr_reg,        ovr_next;
  logic [6:0] en_reg,         en_next;
  logic [7:0] rdata_reg,      rdata_next;
  logic       rvalid_reg,     rvalid_next;
  fuse_cmd_t  fcmd_reg,       fcmd_next;
  logic [7:0] locked_reg,     locked_next;
  logic [6:0] force_reg,      force_next;
  logic       manual_reg,     manual_next;
  logic       boot_reg,       boot_next;

  logic [2:0] cur;
  assign cur = page_index(page_reg);

  // page select: an illegal page code leaves the page unchanged
  always_comb begin
    page_next = page_reg;
    if (cfg_req_in.wr && (cfg_req_in.addr == ADDR_PAGE_SEL)) begin
      if (page_valid(cfg_req_in.wdata)) begin
        page_next = cfg_req_in.wdata;
      end
    end
  end

  // page select register
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      page_reg <= PAGE_MASTER;
    end else begin
      page_reg <= page_next;
    end
  end

  // per-page command byte and fuse write trigger
  always_comb begin
    cmd_next        = cmd_reg;
    fcmd_next       = fcmd_reg;
    fcmd_next.start = 1'b0;
    if (cfg_req_in.wr && (cfg_req_in.addr == ADDR_FUSE_CMD)) begin
      cmd_next[cur] = cfg_req_in.wdata;
      // fire only when the code is newly presented after a clear, so a held code cannot burn twice
      if (is_fuse_cmd(cfg_req_in.wdata) && !is_fuse_cmd(cmd_reg[cur])) begin
        fcmd_next.start     = 1'b1;
        fcmd_next.page      = cur;
        fcmd_next.lock_wake = lock_reg[cur];
      end
    end
  end

  // command registers; start stands one cycle, page and lock byte until the next start
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_PAGES; i++) begin
        cmd_reg[i] <= RST_BYTE;
      end
      fcmd_reg <= '0;
    end else begin
      cmd_reg  <= cmd_next;
      fcmd_reg <= fcmd_next;
    end
  end

  // per-page lock byte and decoded lock status
  always_comb begin
    lock_next = lock_reg;
    if (cfg_req_in.wr && (cfg_req_in.addr == ADDR_LOCK_WAKE)) begin
      lock_next[cur] = cfg_req_in.wdata;
    end
    for (int i = 0; i < NUM_PAGES; i++) begin
      locked_next[i] = (lock_reg[i][LOCK_MSB:LOCK_LSB] == LOCK_CODE);
    end
  end

  // lock registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_PAGES; i++) begin
        lock_reg[i] <= RST_BYTE;
      end
      locked_reg <= RST_BYTE;
    end else begin
      lock_reg   <= lock_next;
      locked_reg <= locked_next;
    end
  end

  // master-page force registers; a subsystem is forced on one cycle after both its bits are set, and off one cycle after either clears
  always_comb begin
    ovr_next   = ovr_reg;
    en_next    = en_reg;
    force_next = ovr_reg & en_reg;
    if (cfg_req_in.wr && (cur == IDX_MASTER)) begin
      if (cfg_req_in.addr == ADDR_FORCE_OVR) begin
        ovr_next = cfg_req_in.wdata[NUM_SUBSYS-1:0];
      end else if (cfg_req_in.addr == ADDR_FORCE_EN) begin
        en_next = cfg_req_in.wdata[NUM_SUBSYS-1:0];
      end
    end
  end

  // force registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ovr_reg   <= RST_FORCE;
      en_reg    <= RST_FORCE;
      force_reg <= RST_FORCE;
    end else begin
      ovr_reg   <= ovr_next;
      en_reg    <= en_next;
      force_reg <= force_next;
    end
  end

  // read mux; a read in the same cycle as a write returns the old value
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = cfg_req_in.rd;
    if (cfg_req_in.rd) begin
      if (cfg_req_in.addr == ADDR_PAGE_SEL) begin
        rdata_next = page_reg;
      end else if (cfg_req_in.addr == ADDR_FUSE_CMD) begin
        rdata_next = cmd_reg[cur];
      end else if (cfg_req_in.addr == ADDR_LOCK_WAKE) begin
        rdata_next = lock_reg[cur];
      end else if ((cfg_req_in.addr == ADDR_FORCE_OVR) && (cur == IDX_MASTER)) begin
        rdata_next = {1'b0, ovr_reg};
      end else if ((cfg_req_in.addr == ADDR_FORCE_EN) && (cur == IDX_MASTER)) begin
        rdata_next = {1'b0, en_reg};
      end else begin
        rdata_next = RST_BYTE; // unmapped reads as zero
      end
    end
  end

  // read data holds until the next read; valid stands one cycle
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rdata_reg  <= RST_BYTE;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // wake mode follows the stored fuse bit, caught once at the first edge after reset release
  always_comb begin
    boot_next   = 1'b0;
    manual_next = manual_reg;
    if (boot_reg) begin
      manual_next = !fuse_wake_dis_in;
    end
  end

  // wake registers; manual wake-up holds through reset until the fuse bit is read
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      manual_reg <= 1'b1;
      boot_reg   <= 1'b1;
    end else begin
      manual_reg <= manual_next;
      boot_reg   <= boot_next;
    end
  end

  assign cfg_rdata_out   = rdata_reg;
  assign cfg_rvalid_out  = rvalid_reg;
  assign page_sel_out    = page_reg;
  assign fuse_cmd_out    = fcmd_reg;
  assign page_locked_out = locked_reg;
  assign force_on_out    = force_reg;
  assign manual_wake_out = manual_reg;

endmodule : efuse_primary_program_control

// File: logic/fuse_prog_pkg.sv
package fuse_prog_pkg;

  // register offsets within a page
  localparam logic [7:0] ADDR_FUSE_CMD    = 8'h0f;
  localparam logic [7:0] ADDR_LOCK_WAKE   = 8'h2f;
  localparam logic [7:0] ADDR_FORCE_OVR   = 8'he0;
  localparam logic [7:0] ADDR_FORCE_EN    = 8'he1;
  localparam logic [7:0] ADDR_PAGE_SEL    = 8'hff;

  // page codes written to the page select register
  localparam logic [7:0] PAGE_MASTER      = 8'h00;
  localparam logic [7:0] PAGE_OUTPUT      = 8'h03;
  localparam logic [7:0] PAGE_SYNTH_A     = 8'h0a;
  localparam logic [7:0] PAGE_SYNTH_D     = 8'h0d;

  // page index space: 0 master, 1 clock monitor, 2 input, 3 output, 4..7 synth a..d
  localparam int          NUM_PAGES       = 8;
  localparam logic [2:0] IDX_MASTER       = 3'h0;
  localparam logic [2:0] IDX_CLKMON       = 3'h1;
  localparam logic [2:0] IDX_INPUT        = 3'h2;
  localparam logic [2:0] IDX_OUTPUT       = 3'h3;
  localparam logic [2:0] IDX_SYNTH_A      = 3'h4;

  // subsystem bit order in the force registers
  localparam int          NUM_SUBSYS      = 7;
  localparam int          SUB_INPUT       = 0;
  localparam int          SUB_CLKMON      = 1;
  localparam int          SUB_OUTPUT      = 2;
  localparam int          SUB_SYNTH_A     = 3;

  // field layouts
  localparam int          CMD_MSB         = 7;
  localparam int          CMD_LSB         = 3;
  localparam logic [4:0] CMD_FUSE_WRITE   = 5'h0c;
  localparam logic [7:0] CMD_BYTE_ALT     = 8'hc0;
  localparam int          LOCK_MSB        = 7;
  localparam int          LOCK_LSB        = 6;
  localparam logic [1:0] LOCK_CODE        = 2'h1;
  localparam int          WAKE_DIS_BIT    = 4;

  // reset values
  localparam logic [7:0] RST_BYTE         = 8'h00;
  localparam logic [6:0] RST_FORCE        = 7'h00;

  // configuration port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;

  // fuse write request towards the fuse macro
  typedef struct packed {
    logic       start;
    logic [2:0] page;
    logic [7:0] lock_wake;
  } fuse_cmd_t;

endpackage : fuse_prog_pkg
